// ### hw/ladder_pkg.sv
// Purpose: Shared constants and types for the ladder bit-logic evaluator.
// Assumes: One 25 MHz clock, asynchronous active-high reset.
// Notes:   Instruction word layout and opcodes are local encodings.
//
// Summary of operation
// RULE1 - Normally open condition equals its operand bit.
// RULE2 - Normally closed condition equals the inverse of its operand bit.
// RULE3 - Load and load-inverted start a block from the operand bit alone.
// RULE4 - Non-load instructions consume the current execution condition.
// RULE5 - Series AND combines condition with the operand bit.
// RULE6 - Inverted AND combines condition with the inverted operand bit.
// RULE7 - Parallel OR combines condition with the operand bit.
// RULE8 - Inverted OR combines condition with the inverted operand bit.
// RULE9 - Instructions evaluate strictly in program order, no precedence.
// RULE10 - Operand bits come from io, special, holding, auxiliary, link, timer areas.
// RULE11 - One address holds one instruction of one to four words; here each word takes its own address and pc steps over the extra words.
// RULE12 - Addresses start at zero and increase; execution starts at zero.
// RULE13 - First word holds opcode and bit operand; later words hold data.
// RULE14 - Entry address advances automatically unless a new address is given.
// RULE15 - Programmer enters mnemonic words one per entry.
// RULE16 - Output drives operand bit from condition; inverted output drives complement.
// RULE17 - Mid-line load saves condition; block-combine merges with last saved.
// RULE18 - Scan runs from zero to first end instruction then repeats.
// RULE19 - Condition register is cleared by reset, updated once per instruction.
package ladder_pkg;

  localparam int WORD_W       = 16;
  localparam int ADDR_W       = 10;
  localparam int BIT_ADDR_W   = 12;
  localparam int STACK_DEPTH  = 8;

  // First word: [15:12] opcode, [11:9] area, [8:0] bit within area.
  localparam int OP_MSB       = 15;
  localparam int OP_LSB       = 12;
  localparam int AREA_MSB     = 11;
  localparam int AREA_LSB     = 9;
  localparam int BIT_MSB      = 8;
  localparam int BIT_LSB      = 0;
  localparam int LEN_MSB      = 1;
  localparam int LEN_LSB      = 0;

  localparam logic [ADDR_W-1:0] START_ADDR = 10'h000;

  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_LOAD      = 4'h1,
    OP_LOAD_INV  = 4'h2,
    OP_AND       = 4'h3,
    OP_AND_INV   = 4'h4,
    OP_OR        = 4'h5,
    OP_OR_INV    = 4'h6,
    OP_AND_BLOCK = 4'h7,
    OP_OR_BLOCK  = 4'h8,
    OP_OUT       = 4'h9,
    OP_OUT_INV   = 4'ha,
    OP_END       = 4'hb,
    OP_DATA      = 4'hc
  } opcode_t;

  typedef enum logic [2:0] {
    AREA_IO    = 3'h0,
    AREA_SPEC  = 3'h1,
    AREA_HOLD  = 3'h2,
    AREA_AUX   = 3'h3,
    AREA_LINK  = 3'h4,
    AREA_TIMER = 3'h5,
    AREA_TEMP  = 3'h6,
    AREA_NONE  = 3'h7
  } area_t;

  typedef struct packed {
    logic              valid;
    logic              set_addr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] word;
  } entry_t;

  typedef struct packed {
    logic                  valid;
    logic                  value;
    logic [BIT_ADDR_W-1:0] addr;
  } bit_write_t;

endpackage

// ### hw/program_memory.sv
// Purpose: Word-addressed program store with registered read data.
// Assumes: One write port for entry, one read port for the scan.
// Notes:   Contents are undefined until entered.
`timescale 1ns/1ps
`default_nettype none
module program_memory #(
  parameter int WIDTH = 16,
  parameter int AW    = 10
) (
  input  wire logic             clock_in,
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic [AW-1:0]    rd_addr_in,
  output var  logic [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    rd_data_out <= mem[rd_addr_in];
  end

endmodule
`default_nettype wire

// ### hw/ladder_bit_logic_evaluator.sv
// Purpose: Fetches ladder instructions and folds operand bits into a condition.
// Assumes: Operand bits read combinationally from the data area port.
// Notes:   Entry and execution are mutually exclusive; entry wins over run.
`timescale 1ns/1ps
`default_nettype none
module ladder_bit_logic_evaluator
  import ladder_pkg::*;
#(
  parameter int DEPTH = ladder_pkg::STACK_DEPTH
) (
  input  wire logic                        clock_in,
  input  wire logic                        sys_rst_in,
  input  wire logic                        run_in,
  input  wire ladder_pkg::entry_t          entry_in,
  output logic [ladder_pkg::ADDR_W-1:0]    entry_addr_out,
  output logic [ladder_pkg::BIT_ADDR_W-1:0] operand_addr_out,
  input  wire logic                        operand_bit_in,
  output ladder_pkg::bit_write_t           bit_write_out,
  output logic                             exec_cond_out,
  output logic [ladder_pkg::ADDR_W-1:0]    pc_out,
  output logic                             scan_done_out,
  output logic                             stack_error_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_EXEC} state_t;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [BIT_ADDR_W-1:0] bit_address(input logic [WORD_W-1:0] w);
    bit_address = {w[AREA_MSB:AREA_LSB], w[BIT_MSB:BIT_LSB]};
  endfunction

  // Total words: only OP_DATA carries an extra-word count in the low bits of the opcode
  // word; every other opcode, bit or non-bit, is always one word.
  function automatic logic [2:0] instr_words(input logic [WORD_W-1:0] w);
    if (opcode_t'(w[OP_MSB:OP_LSB]) == OP_DATA) begin
      instr_words = 3'd1 + {1'b0, w[LEN_MSB:LEN_LSB]};
    end else begin
      instr_words = 3'd1;
    end
  endfunction

  state_t                  state_r;
  logic [ADDR_W-1:0]       pc_r;
  logic [ADDR_W-1:0]       entry_addr_r;
  logic [WORD_W-1:0]       instr_w;
  logic                    cond_r;
  logic                    cond_nxt;
  logic [DEPTH-1:0]        stack_r;
  logic [3:0]              sp_r;
  logic [2:0]              skip_r;
  logic                    op_val;
  logic                    running;
  opcode_t                 op;

  // ------------------------------------------------------------
  // Program memory
  // ------------------------------------------------------------
  program_memory #(.WIDTH(WORD_W), .AW(ADDR_W)) u_mem (
    .clock_in    (clock_in),
    .wr_en_in    (entry_in.valid),
    .wr_addr_in  (entry_in.set_addr ? entry_in.addr : entry_addr_r),
    .wr_data_in  (entry_in.word),
    .rd_addr_in  (pc_r),
    .rd_data_out (instr_w)
  );

  // ------------------------------------------------------------
  // Program entry
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      entry_addr_r <= START_ADDR; // RULE12
    end else if (entry_in.valid) begin
      // Each entered word advances to the next location. // RULE14
      if (entry_in.set_addr) begin
        entry_addr_r <= entry_in.addr + 1'b1;
      end else begin
        entry_addr_r <= entry_addr_r + 1'b1; // RULE11
      end
    end else if (entry_in.set_addr) begin
      entry_addr_r <= entry_in.addr; // RULE14
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      entry_addr_out <= START_ADDR;
    end else if (entry_in.valid && entry_in.set_addr) begin
      entry_addr_out <= entry_in.addr + 1'b1;
    end else if (entry_in.valid) begin
      entry_addr_out <= entry_addr_r + 1'b1;
    end else if (entry_in.set_addr) begin
      entry_addr_out <= entry_in.addr;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  assign running = run_in && !entry_in.valid;
  assign op      = opcode_t'(instr_w[OP_MSB:OP_LSB]); // RULE13
  assign op_val  = operand_bit_in;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
      pc_r    <= START_ADDR;
      skip_r  <= 3'd0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          pc_r <= START_ADDR; // RULE12
          if (running) begin
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_r <= running ? ST_WAIT : ST_IDLE;
        end
        ST_WAIT: begin
          skip_r  <= instr_words(instr_w) - 3'd1; // RULE11
          state_r <= ST_EXEC;
        end
        ST_EXEC: begin
          if (op == OP_END || !running) begin
            pc_r    <= START_ADDR; // RULE18
            state_r <= running ? ST_FETCH : ST_IDLE;
          end else begin
            pc_r    <= pc_r + ADDR_W'(skip_r) + 1'b1; // RULE9 RULE11
            state_r <= ST_FETCH;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      operand_addr_out <= '0;
    end else if (state_r == ST_WAIT) begin
      operand_addr_out <= bit_address(instr_w); // RULE10 RULE13
    end
  end

  // ------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------
  always_comb begin
    cond_nxt = cond_r;
    unique case (op)
      OP_LOAD:      cond_nxt = op_val;             // RULE1 RULE3
      OP_LOAD_INV:  cond_nxt = !op_val;            // RULE2 RULE3
      OP_AND:       cond_nxt = cond_r & op_val;    // RULE4 RULE5
      OP_AND_INV:   cond_nxt = cond_r & !op_val;   // RULE6
      OP_OR:        cond_nxt = cond_r | op_val;    // RULE7
      OP_OR_INV:    cond_nxt = cond_r | !op_val;   // RULE8
      OP_AND_BLOCK: cond_nxt = cond_r & stack_r[0]; // RULE17
      OP_OR_BLOCK:  cond_nxt = cond_r | stack_r[0]; // RULE17
      default:      cond_nxt = cond_r;
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cond_r <= 1'b0; // RULE19
    end else if (state_r == ST_EXEC && running) begin
      cond_r <= cond_nxt; // RULE9 RULE19
    end
  end

  // Saved conditions: a load pushes, a block-combine pops.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stack_r         <= '0;
      sp_r            <= 4'd0;
      stack_error_out <= 1'b0;
    end else if (state_r == ST_EXEC && running) begin
      if (op == OP_END) begin
        sp_r <= 4'd0;
      end else if (op == OP_LOAD || op == OP_LOAD_INV) begin
        stack_r <= {stack_r[DEPTH-2:0], cond_r}; // RULE17
        if (sp_r == 4'(DEPTH)) begin
          stack_error_out <= 1'b1;
        end else begin
          sp_r <= sp_r + 4'd1;
        end
      end else if (op == OP_AND_BLOCK || op == OP_OR_BLOCK) begin
        stack_r <= {1'b0, stack_r[DEPTH-1:1]}; // RULE17
        if (sp_r < 4'd2) begin
          stack_error_out <= 1'b1;
        end
        if (sp_r != 4'd0) begin
          sp_r <= sp_r - 4'd1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_write_out <= '0;
      scan_done_out <= 1'b0;
      exec_cond_out <= 1'b0;
      pc_out        <= START_ADDR;
    end else begin
      bit_write_out.valid <= state_r == ST_EXEC && running && (op == OP_OUT || op == OP_OUT_INV);
      bit_write_out.value <= (op == OP_OUT_INV) ? !cond_r : cond_r; // RULE16
      bit_write_out.addr  <= bit_address(instr_w);
      scan_done_out       <= state_r == ST_EXEC && running && op == OP_END; // RULE18
      exec_cond_out       <= cond_r;
      pc_out              <= pc_r;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence exec_load_s;
    state_r == ST_EXEC && running && op == OP_LOAD;
  endsequence

  load_sets_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE3
    exec_load_s |=> cond_r == $past(op_val)) else $error("load did not set condition");
  load_inv_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE2
    (state_r == ST_EXEC && running && op == OP_LOAD_INV) |=> cond_r == !$past(op_val))
    else $error("inverted load wrong");
  and_series_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE5
    (state_r == ST_EXEC && running && op == OP_AND) |=> cond_r == ($past(cond_r) & $past(op_val)))
    else $error("and wrong");
  and_inv_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE6
    (state_r == ST_EXEC && running && op == OP_AND_INV) |=> cond_r == ($past(cond_r) & !$past(op_val)))
    else $error("and inverted wrong");
  or_parallel_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE7
    (state_r == ST_EXEC && running && op == OP_OR) |=> cond_r == ($past(cond_r) | $past(op_val)))
    else $error("or wrong");
  or_inv_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE8
    (state_r == ST_EXEC && running && op == OP_OR_INV) |=> cond_r == ($past(cond_r) | !$past(op_val)))
    else $error("or inverted wrong");
  cond_stable_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE19
    (state_r != ST_EXEC) |=> $stable(cond_r)) else $error("condition changed outside exec");
  end_restart_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE18
    (state_r == ST_EXEC && running && op == OP_END) |=> pc_r == START_ADDR && scan_done_out)
    else $error("end did not restart scan");
  out_follow_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE16
    (state_r == ST_EXEC && running && op == OP_OUT) |=> bit_write_out.valid && bit_write_out.value == $past(cond_r))
    else $error("output mismatch");

endmodule
`default_nettype wire

// ### testbench/data_area_model.sv
// Purpose: Data-area model that answers operand bit reads and stores output bits.
// Assumes: Reads are combinational from the addressed bit.
// Notes:   All bits start at zero; the bench may preset them between scans.
`timescale 1ns/1ps
`default_nettype none
module data_area_model
  import ladder_pkg::*;
(
  input  wire logic                              clock_in,
  input  wire logic [ladder_pkg::BIT_ADDR_W-1:0] operand_addr_in,
  input  wire ladder_pkg::bit_write_t            bit_write_in,
  output logic                                   operand_bit_out
);
  logic mem [0:(1<<BIT_ADDR_W)-1];

  initial begin
    for (int i = 0; i < (1 << BIT_ADDR_W); i++) mem[i] = 1'b0;
  end

  assign operand_bit_out = mem[operand_addr_in];

  always @(posedge clock_in) begin
    if (bit_write_in.valid === 1'b1) mem[bit_write_in.addr] <= bit_write_in.value;
  end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the ladder bit-logic evaluator.
// Assumes: Inputs change on the falling edge; outputs are sampled there too.
// Notes:   Each test enters a random program, runs one scan and compares outputs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ladder_pkg::*;
  logic                  clock_in   = 1'b0;
  logic                  sys_rst_in = 1'b1;
  logic                  run_in     = 1'b0;
  entry_t                entry_in   = '0;
  logic [ADDR_W-1:0]     entry_addr_out;
  logic [ADDR_W-1:0]     pc_out;
  logic [BIT_ADDR_W-1:0] operand_addr_out;
  logic                  operand_bit_in;
  logic                  exec_cond_out;
  logic                  scan_done_out;
  logic                  stack_error_out;
  bit_write_t            bit_write_out;
  int                    err_count  = 0;
  int                    n_compared = 0;
  logic                  exp_v [$];
  logic [BIT_ADDR_W-1:0] exp_a [$];
  logic [WORD_W-1:0]     prog [$];

  always #20 clock_in = ~clock_in;

  ladder_bit_logic_evaluator #(.DEPTH(STACK_DEPTH)) uut (
    .clock_in         (clock_in),
    .sys_rst_in       (sys_rst_in),
    .run_in           (run_in),
    .entry_in         (entry_in),
    .entry_addr_out   (entry_addr_out),
    .operand_addr_out (operand_addr_out),
    .operand_bit_in   (operand_bit_in),
    .bit_write_out    (bit_write_out),
    .exec_cond_out    (exec_cond_out),
    .pc_out           (pc_out),
    .scan_done_out    (scan_done_out),
    .stack_error_out  (stack_error_out)
  );

  data_area_model dam (
    .clock_in        (clock_in),
    .operand_addr_in (operand_addr_out),
    .bit_write_in    (bit_write_out),
    .operand_bit_out (operand_bit_in)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic test_done();
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Reference model of one condition instruction
  // ----------------------------------------------------------------
  task automatic cond_op(input logic [3:0] op, inout logic c);
    logic [2:0] area;
    logic [8:0] b;
    logic       v;
    area = 3'($urandom_range(5));
    b    = 9'($urandom);
    v    = dam.mem[{area, b}];
    prog.push_back({op, area, b});
    case (op)
      OP_LOAD:     c = v;
      OP_LOAD_INV: c = ~v;
      OP_AND:      c = c & v;
      OP_AND_INV:  c = c & ~v;
      OP_OR:       c = c | v;
      default:     c = c | ~v;
    endcase
  endtask

  // Output bits land in the temporary area so they never feed operands.
  task automatic add_out(input logic inv, input logic [8:0] b, input logic c);
    prog.push_back({inv ? OP_OUT_INV : OP_OUT, AREA_TEMP, b});
    exp_v.push_back(inv ? ~c : c);
    exp_a.push_back({AREA_TEMP, b});
  endtask

  always @(negedge clock_in) begin
    if (bit_write_out.valid === 1'b1) begin
      check(exp_v.size() != 0, 1'b1);
      if (exp_v.size() > 0) begin
        check(bit_write_out.value, exp_v.pop_front());
        check(bit_write_out.addr, exp_a.pop_front());
      end
    end
  end

  initial begin
    #(40 * 60000);
    err_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic c;
    logic s;
    int   n;
    void'($urandom(32'h7c2b));
    repeat (6) @(negedge clock_in);
    sys_rst_in = 1'b0;
    check(exec_cond_out, 1'b0);
    check(entry_addr_out, 0);
    for (int t = 0; t < 24; t++) begin
      prog.delete();
      for (int i = 0; i < 3072; i++) dam.mem[i] = 1'($urandom);
      cond_op($urandom_range(1) ? OP_LOAD : OP_LOAD_INV, c);
      repeat ($urandom_range(4)) cond_op(4'(3 + $urandom_range(3)), c);
      if (t[0]) begin
        s = c;
        cond_op($urandom_range(1) ? OP_LOAD : OP_LOAD_INV, c);
        repeat ($urandom_range(3)) cond_op(4'(3 + $urandom_range(3)), c);
        if ($urandom_range(1)) begin
          prog.push_back({OP_AND_BLOCK, 12'h000});
          c = s & c;
        end else begin
          prog.push_back({OP_OR_BLOCK, 12'h000});
          c = s | c;
        end
      end
      n = t % 4;
      prog.push_back({OP_DATA, 10'h000, 2'(n)});
      repeat (n) prog.push_back(16'($urandom));
      add_out(1'b0, 9'(t), c);
      add_out(1'b1, 9'(t + 256), c);
      prog.push_back({OP_END, 12'h000});
      for (int i = 0; i < prog.size(); i++) begin
        entry_in = '{valid: 1'b1, set_addr: (i == 0), addr: START_ADDR, word: prog[i]};
        @(negedge clock_in);
      end
      entry_in = '0;
      check(entry_addr_out, prog.size());
      run_in = 1'b1;
      for (n = 0; n < 2000 && scan_done_out !== 1'b1; n++) @(negedge clock_in);
      run_in = 1'b0;
      check(scan_done_out, 1'b1);
      check(exp_v.size(), 0);
      repeat (2) @(negedge clock_in);
      check(pc_out, START_ADDR);
      check(exec_cond_out, c);
      check(stack_error_out, 1'b0);
    end
    test_done();
  end
endmodule
`default_nettype wire
